// File: core/tmr16_pkg.sv
// Purpose: Shared constants and types of the 16-bit timer/counter
// Assumes: Byte-wide register port, one system clock
// Notes: Register offsets are word indices on the plain port
package tmr16_pkg;
  // Register port geometry and offsets
  localparam int ADDR_W = 3;
  localparam logic [2:0] OFS_LOW = 3'h0;
  localparam logic [2:0] OFS_HIGH = 3'h1;
  localparam logic [2:0] OFS_CTRL = 3'h2;
  localparam logic [2:0] OFS_STAT = 3'h3;
  localparam logic [2:0] OFS_MASK = 3'h4;
  localparam logic [2:0] OFS_OSC = 3'h5;
  // Control register field positions
  localparam int BIT_RUN = 0;
  localparam int BIT_CSEL = 1;
  localparam int BIT_SYNC_DIS = 2;
  localparam int BIT_STEER_LO = 3;
  localparam int BIT_PS_LO = 4;
  localparam int BIT_PS_HI = 5;
  localparam int BIT_STEER_HI = 6;
  localparam int BIT_WIDE = 7;
  // Status, mask and oscillator register fields
  localparam int BIT_OVF = 0;
  localparam int BIT_OSC_EN = 0;
  // Reset values and constants
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [15:0] COUNT_RESET = 16'h0000;
  localparam logic [15:0] COUNT_MAX = 16'hFFFF;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam logic [2:0] PRESC_ZERO = 3'h0;
  localparam logic [3:0] SPECIAL_EVENT_MODE = 4'hB;
  localparam logic [1:0] PINS_RELEASED = 2'h3;
  localparam logic [1:0] PINS_ZERO = 2'h0;
  localparam int INSTR_DIV_DEFAULT = 4;

  // Request from one capture/compare unit
  typedef struct packed
  {
    logic [3:0] mode;
    logic match;
  } capcomp_req_t;

  // Whole state of the timer/counter
  typedef struct packed
  {
    logic [15:0] count;
    logic [7:0] hi_buf;
    logic [7:0] ctrl;
    logic [2:0] presc;
    logic [7:0] instr_div;
    logic sync_a;
    logic sync_b;
    logic sync_c;
    logic raw_prev;
    logic armed;
    logic [7:0] status;
    logic [7:0] mask;
    logic osc_en;
    logic [7:0] rdata;
    logic irq;
    logic [1:0] pin_oe_n;
    logic [1:0] pin_read;
    logic steer_one;
    logic steer_two;
  } state_t;
endpackage : tmr16_pkg

// File: core/sixteen_bit_timer_counter.sv
// Purpose: 16-bit timer/counter with prescaler, wide access and steering
// Assumes: clk_in is the oscillator clock; pins are synchronous inputs
// Notes: One rule to a line below, tags as used in the code
// Operation
// - Sixteen-bit up-counter, timer or edge counter, two byte registers.
// - Internal source advances once per instruction cycle, clock over four.
// - External source counts rising edges after the first falling edge.
// - Run bit set lets the count advance; clear holds the value.
// - Prescale field divides the input by one, two, four or eight.
// - Sync-disable bit passes the external clock raw, else synchronised.
// - Internal source ignores the sync-disable bit entirely.
// - Steering bits pick which timer serves each capture/compare unit.
// - Oscillator enabled forces both pins to inputs reading zero.
// - Wide bit selects atomic sixteen-bit access, else two byte accesses.
// - Wide mode: high address is a buffer, low read copies high byte.
// - Wide mode: high write loads buffer; low write loads both bytes.
// - Wide mode: no direct path to the live high byte.
// - Low byte write clears prescaler; high byte write leaves it.
// - Count wraps FFFF to 0000 and latches an overflow flag, gated.
// - Special-event compare match from a steered unit resets the count, except in raw external counting.
// - Software write in the same cycle beats the special-event reset.
// - Special-event reset sets the overflow flag only when it meets a tick at FFFF.
//
// The register addresses and strobed register access were decided locally.
`timescale 1ns/10ps
`default_nettype none
module sixteen_bit_timer_counter #(
  parameter int INSTR_DIV = tmr16_pkg::INSTR_DIV_DEFAULT
)
(
  // Clock and reset
  input wire logic clk_in,
  input wire logic resetn_in,
  // Register port
  input wire logic [tmr16_pkg::ADDR_W-1:0] addr_in,
  input wire logic [7:0] wr_data_in,
  input wire logic wr_en_in,
  input wire logic rd_en_in,
  output logic [7:0] rd_data_out,
  // Count sources
  input wire logic external_count_input_in,
  input wire logic lp_osc_in_pin_in,
  // Shared port pins
  input wire logic [1:0] port_direction_bits_in,
  input wire logic [1:0] port_pin_level_in,
  output logic [1:0] pin_oe_n_out,
  output logic [1:0] pin_read_out,
  // Capture/compare units
  input wire tmr16_pkg::capcomp_req_t capcomp_unit_one_in,
  input wire tmr16_pkg::capcomp_req_t capcomp_unit_two_in,
  output logic steer_one_out,
  output logic steer_two_out,
  // Interrupt
  output logic irq_out
);

  // Divider must fit the instruction phase counter
  if (INSTR_DIV < 1 || INSTR_DIV > 256)
  begin : g_bad_div
    $error("INSTR_DIV out of range");
  end

  localparam logic [7:0] INSTR_LAST = 8'(INSTR_DIV - 1);

  tmr16_pkg::state_t s;
  tmr16_pkg::state_t next_s;

  logic use_ext;
  logic sync_on;
  logic wide;
  logic src_level;
  logic rise_sel;
  logic fall_sel;
  logic instr_tick;
  logic in_tick;
  logic adv;
  logic [1:0] ps_code;
  logic [2:0] presc_limit;
  logic presc_last;
  logic count_tick;
  logic wr_low;
  logic wr_high;
  logic count_write;
  logic wrap;
  logic sev_one;
  logic sev_two;
  logic sev;
  logic sev_ok;

  // Decoded control fields
  assign use_ext = s.ctrl[tmr16_pkg::BIT_CSEL];
  assign sync_on = ~s.ctrl[tmr16_pkg::BIT_SYNC_DIS];
  assign wide = s.ctrl[tmr16_pkg::BIT_WIDE];
  assign ps_code = s.ctrl[tmr16_pkg::BIT_PS_HI:tmr16_pkg::BIT_PS_LO];

  // Oscillator, when on, replaces the external pin as the source
  assign src_level = s.osc_en ? lp_osc_in_pin_in : external_count_input_in;

  // Edge pulses; synchronised path costs two cycles of latency
  assign rise_sel = sync_on ? (s.sync_b & ~s.sync_c)
                            : (src_level & ~s.raw_prev);
  assign fall_sel = sync_on ? (~s.sync_b & s.sync_c)
                            : (~src_level & s.raw_prev);

  // Instruction cycle marker, one clock in INSTR_DIV
  assign instr_tick = (s.instr_div == INSTR_LAST);

  // Source select; sync bit plays no part for the internal source
  assign in_tick = use_ext ? (rise_sel & s.armed)
                           : instr_tick;
  assign adv = s.ctrl[tmr16_pkg::BIT_RUN] & in_tick;

  // Prescaler terminal value is ratio minus one
  assign presc_limit = 3'((4'h1 << ps_code) - 4'h1);
  // Compare as at-or-above so a ratio lowered mid-count never runs to wrap
  assign presc_last = (s.presc >= presc_limit);
  assign count_tick = adv & presc_last;

  // Register strobes
  assign wr_low = wr_en_in & (addr_in == tmr16_pkg::OFS_LOW);
  assign wr_high = wr_en_in & (addr_in == tmr16_pkg::OFS_HIGH);
  assign count_write = wr_low | (wr_high & ~wide);

  // A write freezes the count for that cycle, so no wrap either
  assign wrap = count_tick & ~count_write
              & (s.count == tmr16_pkg::COUNT_MAX);

  // Special events only from units steered onto this counter
  assign sev_one = s.steer_one
                 & (capcomp_unit_one_in.mode == tmr16_pkg::SPECIAL_EVENT_MODE)
                 & capcomp_unit_one_in.match;
  assign sev_two = s.steer_two
                 & (capcomp_unit_two_in.mode == tmr16_pkg::SPECIAL_EVENT_MODE)
                 & capcomp_unit_two_in.match;
  assign sev = sev_one | sev_two;
  // Raw external counting does not honour the reset
  assign sev_ok = sev & ~(use_ext & ~sync_on);

  // Next-state logic
  always_comb
  begin
    next_s = s;
    // Free-running instruction phase
    if (instr_tick)
    begin
      next_s.instr_div = tmr16_pkg::BYTE_ZERO;
    end
    else
    begin
      next_s.instr_div = 8'(s.instr_div + 8'h01);
    end
    // Synchroniser and edge history
    next_s.sync_a = src_level;
    next_s.sync_b = s.sync_a;
    next_s.sync_c = s.sync_b;
    next_s.raw_prev = src_level;
    // Arming waits for a falling edge after selecting external
    if (!use_ext)
    begin
      next_s.armed = 1'b0;
    end
    else if (fall_sel)
    begin
      next_s.armed = 1'b1;
    end
    // Prescaler stops with the counter
    if (adv)
    begin
      next_s.presc = presc_last ? tmr16_pkg::PRESC_ZERO
                                : 3'(s.presc + 3'h1);
    end
    if (wr_low)
    begin
      next_s.presc = tmr16_pkg::PRESC_ZERO;
    end
    // Count update: write beats reset beats increment
    if (count_write)
    begin
      if (wr_low)
      begin
        next_s.count[7:0] = wr_data_in;
        if (wide)
        begin
          next_s.count[15:8] = s.hi_buf;
        end
      end
      else
      begin
        next_s.count[15:8] = wr_data_in;
      end
    end
    else if (sev_ok)
    begin
      next_s.count = tmr16_pkg::COUNT_RESET;
    end
    else if (count_tick)
    begin
      next_s.count = 16'(s.count + 16'h0001);
    end
    // High byte buffer
    if (wide && rd_en_in && addr_in == tmr16_pkg::OFS_LOW)
    begin
      next_s.hi_buf = s.count[15:8];
    end
    if (wide && wr_high)
    begin
      next_s.hi_buf = wr_data_in;
    end
    // Control, mask and oscillator registers
    if (wr_en_in && addr_in == tmr16_pkg::OFS_CTRL)
    begin
      next_s.ctrl = wr_data_in;
    end
    if (wr_en_in && addr_in == tmr16_pkg::OFS_MASK)
    begin
      next_s.mask = wr_data_in;
    end
    if (wr_en_in && addr_in == tmr16_pkg::OFS_OSC)
    begin
      next_s.osc_en = wr_data_in[tmr16_pkg::BIT_OSC_EN];
    end
    // Status clears on read, a same-cycle overflow survives
    if (rd_en_in && addr_in == tmr16_pkg::OFS_STAT)
    begin
      next_s.status = tmr16_pkg::BYTE_ZERO;
    end
    if (wrap)
    begin
      next_s.status[tmr16_pkg::BIT_OVF] = 1'b1;
    end
    // Read data stands for one cycle only
    next_s.rdata = tmr16_pkg::BYTE_ZERO;
    if (rd_en_in)
    begin
      case (addr_in)
        tmr16_pkg::OFS_LOW:
          next_s.rdata = s.count[7:0];
        tmr16_pkg::OFS_HIGH:
          next_s.rdata = wide ? s.hi_buf : s.count[15:8];
        tmr16_pkg::OFS_CTRL:
          next_s.rdata = s.ctrl;
        tmr16_pkg::OFS_STAT:
          next_s.rdata = s.status;
        tmr16_pkg::OFS_MASK:
          next_s.rdata = s.mask;
        tmr16_pkg::OFS_OSC:
          next_s.rdata = {7'h00, s.osc_en};
        default:
          next_s.rdata = tmr16_pkg::BYTE_ZERO;
      endcase
    end
    // Interrupt level rises on the same edge as the status bit
    next_s.irq = |(next_s.status & next_s.mask);
    // Pin override while the oscillator owns the pins
    next_s.pin_oe_n = next_s.osc_en ? tmr16_pkg::PINS_RELEASED
                                    : port_direction_bits_in;
    next_s.pin_read = next_s.osc_en ? tmr16_pkg::PINS_ZERO
                                    : port_pin_level_in;
    // Steering: 1x both units, 01 unit two only, 00 neither
    next_s.steer_one = next_s.ctrl[tmr16_pkg::BIT_STEER_HI];
    next_s.steer_two = next_s.ctrl[tmr16_pkg::BIT_STEER_HI]
                     | next_s.ctrl[tmr16_pkg::BIT_STEER_LO];
  end

  // State register
  always_ff @(posedge clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      s <= '0;
      s.ctrl <= tmr16_pkg::CTRL_RESET;
      s.count <= tmr16_pkg::COUNT_RESET;
      s.pin_oe_n <= tmr16_pkg::PINS_RELEASED;
    end
    else
    begin
      s <= next_s;
    end
  end

  // Outputs straight from the state flops
  assign rd_data_out = s.rdata;
  assign pin_oe_n_out = s.pin_oe_n;
  assign pin_read_out = s.pin_read;
  assign steer_one_out = s.steer_one;
  assign steer_two_out = s.steer_two;
  assign irq_out = s.irq;

  // Checks
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!resetn_in);

  // Internal source at 1:1 advances exactly once per instruction tick
  a_internal_rate_step: assert property (
    instr_tick && !use_ext && s.ctrl[tmr16_pkg::BIT_RUN]
    && ps_code == 2'h0 && !wr_en_in && !sev_ok
    |=> s.count == 16'($past(s.count) + 16'h0001))
    else $error("internal tick did not advance count");

  // Stopped counter holds its value when left alone
  a_stopped_count_holds: assert property (
    !s.ctrl[tmr16_pkg::BIT_RUN] && !wr_en_in && !sev_ok
    |=> $stable(s.count))
    else $error("stopped counter moved");

  // Low byte write clears the prescaler
  a_prescale_clear_low: assert property (
    wr_low |=> s.presc == tmr16_pkg::PRESC_ZERO)
    else $error("prescaler not cleared by low write");

  // High byte write leaves the prescaler alone
  a_prescale_keep_high: assert property (
    wr_high && !adv |=> $stable(s.presc))
    else $error("prescaler disturbed by high write");

  // Wide low read snapshots the live high byte
  a_wide_read_snap: assert property (
    wide && rd_en_in && addr_in == tmr16_pkg::OFS_LOW
    |=> s.hi_buf == $past(s.count[15:8]))
    else $error("buffer missed high byte snapshot");

  // Wide low write loads both bytes at once
  a_wide_write_pair: assert property (
    wide && wr_low
    |=> s.count == {$past(s.hi_buf), $past(wr_data_in)})
    else $error("wide write did not load both bytes");

  // Wide high write touches only the buffer
  a_wide_high_buffer: assert property (
    wide && wr_high && !count_tick && !sev_ok
    |=> s.hi_buf == $past(wr_data_in) && $stable(s.count))
    else $error("wide high write reached live count");

  // Overflow sets the flag and, when unmasked, the interrupt together
  a_overflow_flag_irq: assert property (
    wrap && s.mask[tmr16_pkg::BIT_OVF] && !wr_en_in
    |=> s.status[tmr16_pkg::BIT_OVF] && s.count == tmr16_pkg::COUNT_RESET
    && irq_out)
    else $error("overflow flag or interrupt missing");

  // Special event clears the count when no write coincides
  a_event_reset_count: assert property (
    sev_ok && !count_write |=> s.count == tmr16_pkg::COUNT_RESET)
    else $error("special event did not reset count");

  // Write wins over a coinciding special event
  a_write_beats_event: assert property (
    sev_ok && wr_low |=> s.count[7:0] == $past(wr_data_in))
    else $error("special event beat software write");

  // Only a wrap can raise the overflow flag
  a_flag_only_wrap: assert property (
    $rose(s.status[tmr16_pkg::BIT_OVF]) |-> $past(wrap))
    else $error("overflow flag set without wrap");

  // Oscillator owns the pins
  a_osc_pin_force: assert property (
    s.osc_en |-> pin_oe_n_out == tmr16_pkg::PINS_RELEASED
    && pin_read_out == tmr16_pkg::PINS_ZERO)
    else $error("pins not forced while oscillator on");

  // Unit one is never steered without unit two
  a_steer_decode: assert property (
    steer_one_out |-> steer_two_out)
    else $error("unit one steered without unit two");

endmodule : sixteen_bit_timer_counter
`default_nettype wire

// File: verif/tmr16_partner.sv
// Purpose: Far-side model: capture/compare units and external count clock
// Assumes: Commands arrive from the bench on the system clock
// Notes: Count clock rests high between bursts, so a burst starts with a fall
`timescale 1ns/10ps
`default_nettype none
module tmr16_partner
(
  // Clock and commands
  input wire logic clk_in,
  input wire logic ext_run_in,
  input wire logic fire_in,
  input wire logic unit_sel_in,
  input wire logic [3:0] mode_in,
  // Toward the timer
  output var logic ext_clk_out,
  output var tmr16_pkg::capcomp_req_t unit_one_out,
  output var tmr16_pkg::capcomp_req_t unit_two_out
);
  logic [2:0] phase;

  // Outputs settle on the first edge, well inside the bench reset
  // Count clock toggles every eight system clocks while a burst runs
  always @(posedge clk_in)
  begin
    phase <= ext_run_in ? phase + 3'h1 : 3'h0;
    if (!ext_run_in)
      ext_clk_out <= 1'b1;
    else if (phase == 3'h7)
      ext_clk_out <= ~ext_clk_out;
  end

  // One-cycle match on the chosen unit; the other unit shows a quiet mode
  always @(posedge clk_in)
  begin
    unit_one_out.mode <= unit_sel_in ? 4'h0 : mode_in;
    unit_two_out.mode <= unit_sel_in ? mode_in : 4'h0;
    unit_one_out.match <= fire_in && !unit_sel_in;
    unit_two_out.match <= fire_in && unit_sel_in;
  end
endmodule : tmr16_partner
`default_nettype wire

// File: verif/tb.sv
// Purpose: Self-checking bench of the 16-bit timer/counter
// Assumes: Offsets 0 low, 1 high, 2 control, 3 status, 4 mask, 5 oscillator
// Notes: Read expectations queue at the strobe; a monitor checks them later
`timescale 1ns/10ps
`default_nettype none
module tb;
  logic clk_in;
  logic resetn_in;
  logic [tmr16_pkg::ADDR_W-1:0] addr_in;
  logic [7:0] wr_data_in;
  logic wr_en_in;
  logic rd_en_in;
  logic [7:0] rd_data_out;
  logic ext_clk;
  logic ext_run;
  logic fire;
  logic unit_sel;
  logic [3:0] mode;
  logic [1:0] dir;
  logic [1:0] lvl;
  logic [1:0] pin_oe_n_out;
  logic [1:0] pin_read_out;
  tmr16_pkg::capcomp_req_t req_one;
  tmr16_pkg::capcomp_req_t req_two;
  logic steer_one_out;
  logic steer_two_out;
  logic irq_out;
  logic rd_seen;
  logic [7:0] exp_q[$];
  logic [31:0] seed;
  logic [7:0] hi;
  logic [7:0] lo;
  logic hit;
  int n_errors;
  int check_count;

  sixteen_bit_timer_counter u_sixteen_bit_timer_counter
  (
    .clk_in(clk_in), .resetn_in(resetn_in), .addr_in(addr_in),
    .wr_data_in(wr_data_in), .wr_en_in(wr_en_in), .rd_en_in(rd_en_in),
    .rd_data_out(rd_data_out), .external_count_input_in(ext_clk),
    .lp_osc_in_pin_in(1'b0), .port_direction_bits_in(dir),
    .port_pin_level_in(lvl), .pin_oe_n_out(pin_oe_n_out),
    .pin_read_out(pin_read_out), .capcomp_unit_one_in(req_one),
    .capcomp_unit_two_in(req_two), .steer_one_out(steer_one_out),
    .steer_two_out(steer_two_out), .irq_out(irq_out)
  );

  tmr16_partner u_tmr16_partner
  (
    .clk_in(clk_in), .ext_run_in(ext_run), .fire_in(fire),
    .unit_sel_in(unit_sel), .mode_in(mode), .ext_clk_out(ext_clk),
    .unit_one_out(req_one), .unit_two_out(req_two)
  );

  // 200 MHz system clock
  initial
  begin
    clk_in = 1'b0;
    forever #2.5 clk_in = ~clk_in;
  end

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] v;
    v = s ^ (s << 13);
    v = v ^ (v >> 17);
    xs = v ^ (v << 5);
  endfunction : xs

  task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp)
    begin
      n_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp

  // Port levels are checked through the byte compare, zero-extended
  task automatic cmp_pin(input logic [1:0] got, input logic [1:0] exp);
    cmp({6'h00, got}, {6'h00, exp});
  endtask : cmp_pin

  // Strobe is dropped a full cycle later so back-to-back calls never clash
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    addr_in <= a;
    wr_data_in <= d;
    wr_en_in <= 1'b1;
    @(posedge clk_in);
    wr_en_in <= 1'b0;
    @(posedge clk_in);
  endtask : wr

  task automatic rd(input logic [2:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    addr_in <= a;
    rd_en_in <= 1'b1;
    @(posedge clk_in);
    rd_en_in <= 1'b0;
    @(posedge clk_in);
  endtask : rd

  task automatic fire_at(input logic u, input logic [3:0] m);
    unit_sel <= u;
    mode <= m;
    fire <= 1'b1;
    @(posedge clk_in);
    fire <= 1'b0;
  endtask : fire_at

  task automatic conclude;
    $display("Comparisons %0d, mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : conclude

  // Read data stand only in the cycle after the strobe; sample mid-cycle
  always @(posedge clk_in)
    rd_seen <= rd_en_in;
  always @(negedge clk_in)
  begin
    if (rd_seen === 1'b1)
      cmp(rd_data_out, exp_q.pop_front());
  end

  // Watchdog well beyond the under one thousand cycles the run needs
  initial
  begin
    repeat (20000) @(posedge clk_in);
    n_errors++;
    conclude();
  end

  initial
  begin
    resetn_in = 1'b0;
    addr_in = '0;
    wr_data_in = 8'h00;
    wr_en_in = 1'b0;
    rd_en_in = 1'b0;
    ext_run = 1'b0;
    fire = 1'b0;
    unit_sel = 1'b0;
    mode = 4'h0;
    dir = 2'h3;
    lvl = 2'h0;
    seed = 32'h000144F4;
    n_errors = 0;
    check_count = 0;
    repeat (8) @(posedge clk_in);
    resetn_in <= 1'b1;
    @(posedge clk_in);
    rd(3'h2, tmr16_pkg::CTRL_RESET);
    rd(3'h6, 8'h00);
    // Run windows of 64 edges give exactly 16 instruction ticks
    for (int c = 0; c < 4; c++)
    begin
      wr(3'h0, 8'h00);
      wr(3'h1, 8'h00);
      wr(3'h2, {2'h0, 2'(c), 1'b0, c[0], 2'h1});
      repeat (62) @(posedge clk_in);
      wr(3'h2, 8'h00);
      rd(3'h0, 8'(16 >> c));
      rd(3'h0, 8'(16 >> c));
    end
    // Two ticks from FFFE wrap the count, masked then unmasked
    for (int m = 0; m < 2; m++)
    begin
      wr(3'h4, 8'(m));
      wr(3'h1, 8'hFF);
      wr(3'h0, 8'hFE);
      wr(3'h2, 8'h01);
      repeat (6) @(posedge clk_in);
      wr(3'h2, 8'h00);
      repeat (2) @(posedge clk_in);
      #1;
      cmp_pin({1'b0, irq_out}, 2'(m));
      @(posedge clk_in);
      rd(3'h0, 8'h00);
      rd(3'h3, 8'h01);
      rd(3'h3, 8'h00);
      #1;
      cmp_pin({1'b0, irq_out}, 2'h0);
      @(posedge clk_in);
    end
    seed = xs(seed);
    hi = seed[7:0];
    lo = seed[15:8];
    wr(3'h2, 8'h80);
    wr(3'h1, hi);
    wr(3'h0, lo);
    rd(3'h0, lo);
    rd(3'h1, hi);
    wr(3'h1, ~hi);
    rd(3'h0, lo);
    rd(3'h1, hi);
    wr(3'h2, 8'h00);
    rd(3'h1, hi);
    wr(3'h1, ~hi);
    rd(3'h1, ~hi);
    rd(3'h0, lo);
    // Every steering code against a special event from each unit
    for (int s = 0; s < 8; s++)
    begin
      wr(3'h2, {1'b0, s[1], 2'h0, s[0], 3'h0});
      #1;
      cmp_pin({steer_two_out, steer_one_out}, {s[1] | s[0], s[1]});
      @(posedge clk_in);
      hit = s[2] ? (s[1] | s[0]) : s[1];
      wr(3'h1, 8'h12);
      wr(3'h0, 8'h34);
      fire_at(s[2], tmr16_pkg::SPECIAL_EVENT_MODE);
      repeat (2) @(posedge clk_in);
      rd(3'h0, hit ? 8'h00 : 8'h34);
      rd(3'h1, hit ? 8'h00 : 8'h12);
    end
    rd(3'h3, 8'h00);
    wr(3'h2, 8'h40);
    wr(3'h0, 8'h34);
    fire_at(1'b0, 4'hA);
    repeat (2) @(posedge clk_in);
    rd(3'h0, 8'h34);
    // Software write lands on the same edge as the trigger
    fire_at(1'b0, tmr16_pkg::SPECIAL_EVENT_MODE);
    wr(3'h0, 8'h55);
    rd(3'h0, 8'h55);
    // Five external pulses, synchronised then raw
    for (int y = 0; y < 2; y++)
    begin
      wr(3'h0, 8'h00);
      wr(3'h1, 8'h00);
      wr(3'h2, {5'h00, y[0], 2'h3});
      ext_run <= 1'b1;
      repeat (80) @(posedge clk_in);
      ext_run <= 1'b0;
      repeat (8) @(posedge clk_in);
      wr(3'h2, 8'h00);
      rd(3'h0, 8'h05);
    end
    // Random pin settings, oscillator off then on
    for (int k = 0; k < 8; k++)
    begin
      if (k == 4)
        wr(3'h5, 8'h01);
      seed = xs(seed);
      dir <= seed[1:0];
      lvl <= seed[3:2];
      repeat (3) @(posedge clk_in);
      #1;
      cmp_pin(pin_oe_n_out, k < 4 ? dir : 2'h3);
      cmp_pin(pin_read_out, k < 4 ? lvl : 2'h0);
      @(posedge clk_in);
    end
    repeat (4) @(posedge clk_in);
    conclude();
  end
endmodule : tb
`default_nettype wire
